/* File: ee_pkg.sv */
// Overview of operation
// - no acknowledge at all while write cycle runs
// - stop after write data starts timed write
// - master polls with write control byte
// - poll unanswered while busy, acknowledged after
// - direction bit one selects a read
// - pointer holds last accessed location plus one, wrapped within the 8-byte page after a write
// - acknowledge read control byte, send one byte
// - master leaves last byte unacknowledged, then stops
// - random read loads address in write first
// - repeated start aborts write, pointer still loaded
// - after repeated start, master resends read control
// - master acknowledge fetches next consecutive byte
// - pointer advances by one per byte transferred, wrapping within its 8-byte page on writes
// - clock and data inputs filtered against spikes
// - control code 1010, three ignored bits, direction
// - only low seven address bits are used
// - release data line after unacknowledged last byte
package ee_pkg;
   localparam int CLK_NS = 8;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam logic [3:0] CTRL_CODE = 4'ha;
   localparam logic [2:0] CTRL_DONT_CARE = 3'h0;
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic [ADDR_W-1:0] PAGE_MASK = 7'h07;
   localparam logic [ADDR_W-1:0] FULL_MASK = 7'h7f;
   localparam int BUS_IDLE_BITS = 2;
   localparam int QTR_DEF = 60;
   localparam int WR_CYC_DEF = 625000;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      K_WRITE = 2'h0,
      K_POLL = 2'h1,
      K_CUR = 2'h2,
      K_RAND = 2'h3
   } ee_kind_t;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_CTRL = 7'h02,
      S_ADDR = 7'h04,
      S_DATA = 7'h08,
      S_ACK = 7'h10,
      S_TX = 7'h20,
      S_MACK = 7'h40
   } ee_sst_t;

   typedef enum logic [4:0] {
      M_IDLE = 5'h01,
      M_START = 5'h02,
      M_TX = 5'h04,
      M_RX = 5'h08,
      M_STOP = 5'h10
   } ee_mst_t;
endpackage

/* File: ee_bus_if.sv */
interface ee_bus_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // open-drain wired-and with pull-up
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

   modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input sda);
   modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

/* File: ee_fifo.sv */
module ee_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic CLK, // clock
   input wire logic RST, // async reset
   input wire logic CE, // clock enable
   input wire logic IN_VALID, // write request
   output logic IN_READY, // room left
   input wire logic [W-1:0] IN_DATA, // write word
   output logic OUT_VALID, // word available
   input wire logic OUT_READY, // consumer takes word
   output logic [W-1:0] OUT_DATA // head word
);
   localparam int AW = $clog2(D);

   if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
      $error("fifo depth must be a power of two");
   end

   logic [W-1:0] mem [D];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   wire empty = (wp_reg == rp_reg);
   wire push = IN_VALID && !full;
   wire pop = OUT_READY && !empty;

   assign IN_READY = !full;
   assign OUT_VALID = !empty;
   assign OUT_DATA = mem[rp_reg[AW-1:0]];

   always_ff @(posedge CLK) begin
      if (CE && push) begin
         mem[wp_reg[AW-1:0]] <= IN_DATA;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else if (CE) begin
         if (push) wp_reg <= wp_reg + 1'b1;
         if (pop) rp_reg <= rp_reg + 1'b1;
      end
   end
endmodule

/* File: ee_slave.sv */
module ee_slave #(
   parameter int WR_CYC = ee_pkg::WR_CYC_DEF,
   parameter int FILT = ee_pkg::FILT_CYC
) (
   input wire logic CLK, // clock
   input wire logic RST, // async reset
   input wire logic CE, // clock enable
   ee_bus_if.slave BUS, // two-wire bus
   output logic BUSY, // write cycle running
   output logic [ee_pkg::ADDR_W-1:0] PTR // address pointer
);
   import ee_pkg::*;

   localparam int FW = $clog2(FILT + 1);
   localparam int BW = $clog2(WR_CYC + 1);
   localparam logic [FW-1:0] FILT_LAST = FW'(FILT - 1);
   localparam logic [BW-1:0] WR_LOAD = BW'(WR_CYC);
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int MEM_D = 1 << ADDR_W;

   if (WR_CYC < 1 || FILT < 1) begin : g_chk
      $error("write cycle and filter length must be at least one");
   end

   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                              input logic [ADDR_W-1:0] m);
      return (a & ~m) | ((a + 1'b1) & m);
   endfunction

   logic [BYTE_W-1:0] mem [MEM_D];

   logic [1:0] s1_reg;
   logic [1:0] s2_reg;
   logic [1:0] f_reg;
   logic [1:0] fp_reg;
   logic [FW-1:0] fc_reg [2];

   ee_sst_t st_reg;
   ee_sst_t go_reg;
   logic [BYTE_W-1:0] rx_reg;
   logic [BYTE_W-1:0] tx_reg;
   logic [2:0] bcnt_reg;
   logic full_reg;
   logic mack_reg;
   logic wpend_reg;
   logic [ADDR_W-1:0] ptr_reg;
   logic [BW-1:0] bcy_reg;
   logic busy_reg;
   logic sda_low_reg;

   // synchroniser, then a line only flips after FILT stable cycles
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1_reg <= 2'h3;
         s2_reg <= 2'h3;
         f_reg <= 2'h3;
         fp_reg <= 2'h3;
         fc_reg[0] <= '0;
         fc_reg[1] <= '0;
      end else if (CE) begin
         s1_reg <= {BUS.scl, BUS.sda};
         s2_reg <= s1_reg;
         fp_reg <= f_reg;
         for (int i = 0; i < 2; i++) begin
            if (s2_reg[i] == f_reg[i]) begin
               fc_reg[i] <= '0;
            end else if (fc_reg[i] == FILT_LAST) begin
               f_reg[i] <= s2_reg[i];
               fc_reg[i] <= '0;
            end else begin
               fc_reg[i] <= fc_reg[i] + 1'b1;
            end
         end
      end
   end

   wire scl_f = f_reg[1];
   wire sda_f = f_reg[0];
   wire rise = scl_f && !fp_reg[1];
   wire fall = !scl_f && fp_reg[1];
   wire start_c = scl_f && fp_reg[1] && fp_reg[0] && !sda_f;
   wire stop_c = scl_f && fp_reg[1] && !fp_reg[0] && sda_f;
   wire rcv_st = (st_reg == S_CTRL) || (st_reg == S_ADDR) || (st_reg == S_DATA);
   wire code_ok = (rx_reg[7:4] == CTRL_CODE);
   wire ctrl_ok = code_ok && !busy_reg;
   wire is_rd = (rx_reg[0] == RW_READ);
   wire mem_we = fall && full_reg && (st_reg == S_DATA);
   wire [BYTE_W-1:0] rd_byte = mem[ptr_reg];
   wire [ADDR_W-1:0] rd_next = step(ptr_reg, FULL_MASK);
   wire [ADDR_W-1:0] wr_next = step(ptr_reg, PAGE_MASK);
   wire drive_low = (st_reg == S_ACK) || ((st_reg == S_TX) && !tx_reg[BYTE_W-1]);

   always_ff @(posedge CLK) begin
      if (CE && mem_we) begin
         mem[ptr_reg] <= rx_reg;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_reg <= S_IDLE;
         go_reg <= S_IDLE;
         rx_reg <= '0;
         tx_reg <= '0;
         bcnt_reg <= '0;
         full_reg <= 1'b0;
         mack_reg <= 1'b0;
         wpend_reg <= 1'b0;
         ptr_reg <= '0;
         bcy_reg <= '0;
         busy_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else if (CE) begin
         sda_low_reg <= drive_low;
         if (bcy_reg != '0) begin
            bcy_reg <= bcy_reg - 1'b1;
            if (bcy_reg == BW'(1)) busy_reg <= 1'b0;
         end
         if (start_c) begin
            // a repeated start drops the pending write, pointer kept
            st_reg <= S_CTRL;
            bcnt_reg <= '0;
            full_reg <= 1'b0;
            wpend_reg <= 1'b0;
         end else if (stop_c) begin
            st_reg <= S_IDLE;
            wpend_reg <= 1'b0;
            if (wpend_reg) begin
               bcy_reg <= WR_LOAD;
               busy_reg <= 1'b1;
            end
         end else if (rise) begin
            if (rcv_st) begin
               rx_reg <= {rx_reg[BYTE_W-2:0], sda_f};
               bcnt_reg <= bcnt_reg + 1'b1;
               full_reg <= (bcnt_reg == LAST_BIT);
            end
            if (st_reg == S_MACK) begin
               mack_reg <= !sda_f;
            end
         end else if (fall) begin
            unique case (st_reg)
               S_IDLE: begin
               end
               S_CTRL: begin
                  if (full_reg) begin
                     full_reg <= 1'b0;
                     bcnt_reg <= '0;
                     if (ctrl_ok) begin
                        st_reg <= S_ACK;
                        go_reg <= is_rd ? S_TX : S_ADDR;
                     end else begin
                        st_reg <= S_IDLE;
                     end
                  end
               end
               S_ADDR: begin
                  if (full_reg) begin
                     full_reg <= 1'b0;
                     bcnt_reg <= '0;
                     ptr_reg <= rx_reg[ADDR_W-1:0];
                     st_reg <= S_ACK;
                     go_reg <= S_DATA;
                  end
               end
               S_DATA: begin
                  if (full_reg) begin
                     full_reg <= 1'b0;
                     bcnt_reg <= '0;
                     ptr_reg <= wr_next;
                     wpend_reg <= 1'b1;
                     st_reg <= S_ACK;
                     go_reg <= S_DATA;
                  end
               end
               S_ACK: begin
                  st_reg <= go_reg;
                  bcnt_reg <= '0;
                  if (go_reg == S_TX) begin
                     tx_reg <= rd_byte;
                     ptr_reg <= rd_next;
                  end
               end
               S_TX: begin
                  tx_reg <= {tx_reg[BYTE_W-2:0], 1'b1};
                  bcnt_reg <= bcnt_reg + 1'b1;
                  if (bcnt_reg == LAST_BIT) begin
                     st_reg <= S_MACK;
                     mack_reg <= 1'b0;
                  end
               end
               S_MACK: begin
                  bcnt_reg <= '0;
                  if (mack_reg) begin
                     st_reg <= S_TX;
                     tx_reg <= rd_byte;
                     ptr_reg <= rd_next;
                  end else begin
                     st_reg <= S_IDLE;
                  end
               end
               default: st_reg <= S_IDLE;
            endcase
         end
      end
   end

   assign BUS.s_sda_o = 1'b0;
   assign BUS.s_sda_oe = sda_low_reg;
   assign BUSY = busy_reg;
   assign PTR = ptr_reg;
endmodule

/* File: ee_master.sv */
module ee_master #(
   parameter int QTR = ee_pkg::QTR_DEF,
   parameter int LEN_W = 8,
   parameter int DEPTH = ee_pkg::FIFO_DEPTH
) (
   input wire logic CLK, // clock
   input wire logic RST, // async reset
   input wire logic CE, // clock enable
   ee_bus_if.master BUS, // two-wire bus
   input wire logic CMD_VALID, // command request
   output logic CMD_READY, // idle, command taken
   input wire ee_pkg::ee_kind_t CMD_KIND, // transfer type
   input wire logic [ee_pkg::BYTE_W-1:0] CMD_ADDR, // word address
   input wire logic [ee_pkg::BYTE_W-1:0] CMD_DATA, // write byte
   input wire logic [LEN_W-1:0] CMD_LEN, // read byte count, 0 means 1
   output logic RD_VALID, // read byte available
   input wire logic RD_READY, // read byte taken
   output logic [ee_pkg::BYTE_W-1:0] RD_DATA, // read byte
   output logic DONE, // command finished pulse
   output logic NACK // last command refused
);
   import ee_pkg::*;

   localparam int DW = $clog2(QTR);
   localparam logic [DW-1:0] DIV_LAST = DW'(QTR - 1);
   localparam logic [3:0] ACK_BIT = 4'h8;

   if (QTR < 8 * FILT_CYC || LEN_W < 1) begin : g_chk
      $error("quarter bit too short for the slave filter");
   end

   ee_mst_t st_reg;
   ee_kind_t kind_reg;
   logic [BYTE_W-1:0] addr_reg;
   logic [BYTE_W-1:0] data_reg;
   logic [LEN_W-1:0] left_reg;
   logic [1:0] seg_reg;
   logic rsent_reg;
   logic [DW-1:0] div_reg;
   logic [1:0] q_reg;
   logic [3:0] bit_reg;
   logic [BYTE_W:0] sh_reg;
   logic [BYTE_W:0] rcv_reg;
   logic scl_reg;
   logic sda_reg;
   logic done_reg;
   logic nack_reg;
   logic s1_reg;
   logic s2_reg;
   logic f_ready;

   wire in_byte = (st_reg == M_TX) || (st_reg == M_RX);
   wire stall = (st_reg == M_RX) && (bit_reg == '0) && (q_reg == '0) && !f_ready;
   wire tick = (st_reg != M_IDLE) && (div_reg == DIV_LAST) && !stall;
   wire seg_end = tick && (q_reg == 2'h3) && (!in_byte || bit_reg == ACK_BIT);
   wire rd_now = (kind_reg == K_CUR) || rsent_reg;
   wire slave_ack = !rcv_reg[0];
   wire last_rx = (left_reg == LEN_W'(1));
   wire next_last = (left_reg == LEN_W'(2));
   wire [BYTE_W:0] ctrl_sh = {CTRL_CODE, CTRL_DONT_CARE, rd_now, 1'b1};
   wire [BYTE_W:0] rx_first = {8'hff, last_rx};
   wire [BYTE_W:0] rx_more = {8'hff, next_last};
   wire scl_w = (st_reg == M_IDLE) || (st_reg == M_STOP && q_reg != 2'h0) ||
                (st_reg == M_START && (q_reg == 2'h1 || q_reg == 2'h2)) ||
                (in_byte && q_reg[1]);
   wire sda_w = (st_reg == M_IDLE) || (st_reg == M_STOP && q_reg[1]) ||
                (st_reg == M_START && !q_reg[1]) ||
                (in_byte && (q_reg == 2'h0 ? sda_reg : sh_reg[BYTE_W]));

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_reg <= M_IDLE;
         kind_reg <= K_WRITE;
         addr_reg <= '0;
         data_reg <= '0;
         left_reg <= '0;
         seg_reg <= '0;
         rsent_reg <= 1'b0;
         div_reg <= '0;
         q_reg <= '0;
         bit_reg <= '0;
         sh_reg <= '1;
         rcv_reg <= '1;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         done_reg <= 1'b0;
         nack_reg <= 1'b0;
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
      end else if (CE) begin
         s1_reg <= BUS.sda;
         s2_reg <= s1_reg;
         scl_reg <= scl_w;
         sda_reg <= sda_w;
         done_reg <= 1'b0;
         if (st_reg == M_IDLE) begin
            div_reg <= '0;
            q_reg <= '0;
            if (CMD_VALID) begin
               st_reg <= M_START;
               kind_reg <= CMD_KIND;
               addr_reg <= CMD_ADDR;
               data_reg <= CMD_DATA;
               left_reg <= (CMD_LEN == '0) ? LEN_W'(1) : CMD_LEN;
               rsent_reg <= 1'b0;
               nack_reg <= 1'b0;
            end
         end else if (!stall) begin
            div_reg <= tick ? '0 : div_reg + 1'b1;
         end
         if (tick) begin
            q_reg <= q_reg + 1'b1;
            if (in_byte && q_reg == 2'h2) rcv_reg <= {rcv_reg[BYTE_W-1:0], s2_reg};
            if (in_byte && q_reg == 2'h3) begin
               sh_reg <= {sh_reg[BYTE_W-1:0], 1'b1};
               bit_reg <= bit_reg + 1'b1;
            end
         end
         if (seg_end) begin
            bit_reg <= '0;
            unique case (st_reg)
               M_START: begin
                  st_reg <= M_TX;
                  sh_reg <= ctrl_sh;
                  seg_reg <= 2'h0;
               end
               M_TX: begin
                  if (!slave_ack) begin
                     nack_reg <= 1'b1;
                     st_reg <= M_STOP;
                  end else if (seg_reg == 2'h0 && rd_now) begin
                     st_reg <= M_RX;
                     sh_reg <= rx_first;
                  end else if (seg_reg == 2'h0 && kind_reg == K_POLL) begin
                     st_reg <= M_STOP;
                  end else if (seg_reg == 2'h0) begin
                     sh_reg <= {addr_reg, 1'b1};
                     seg_reg <= 2'h1;
                  end else if (seg_reg == 2'h1 && kind_reg == K_WRITE) begin
                     sh_reg <= {data_reg, 1'b1};
                     seg_reg <= 2'h2;
                  end else if (seg_reg == 2'h1) begin
                     st_reg <= M_START;
                     rsent_reg <= 1'b1;
                  end else begin
                     st_reg <= M_STOP;
                  end
               end
               M_RX: begin
                  left_reg <= left_reg - 1'b1;
                  if (last_rx) begin
                     st_reg <= M_STOP;
                  end else begin
                     sh_reg <= rx_more;
                  end
               end
               M_STOP: begin
                  st_reg <= M_IDLE;
                  done_reg <= 1'b1;
               end
               default: st_reg <= M_IDLE;
            endcase
         end
      end
   end

   ee_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .IN_VALID(CE && seg_end && st_reg == M_RX),
      .IN_READY(f_ready),
      .IN_DATA(rcv_reg[BYTE_W:1]),
      .OUT_VALID(RD_VALID),
      .OUT_READY(RD_READY),
      .OUT_DATA(RD_DATA)
   );

   assign BUS.scl_o = 1'b0;
   assign BUS.scl_oe = !scl_reg;
   assign BUS.m_sda_o = 1'b0;
   assign BUS.m_sda_oe = !sda_reg;
   assign CMD_READY = (st_reg == M_IDLE);
   assign DONE = done_reg;
   assign NACK = nack_reg;
endmodule

/* File: ee_bus_props.sv */
module ee_bus_props #(
   parameter int WR_CYC = ee_pkg::WR_CYC_DEF
) (
   input wire logic CLK, // clock
   input wire logic RST, // async reset
   input wire logic scl_o, // master clock level
   input wire logic scl_oe, // master pulls clock
   input wire logic m_sda_o, // master data level
   input wire logic m_sda_oe, // master pulls data
   input wire logic s_sda_o, // slave data level
   input wire logic s_sda_oe, // slave pulls data
   input wire logic scl, // clock wire
   input wire logic sda, // data wire
   input wire logic BUSY, // write cycle
   input wire logic [ee_pkg::ADDR_W-1:0] PTR // pointer
);
   timeunit 1ns;
   timeprecision 100ps;
   import ee_pkg::*;
   logic [31:0] busy_cnt_reg;
   logic [31:0] busy_cnt_next;
   assign busy_cnt_next = BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_cnt_reg <= 32'h0;
      end else begin
         busy_cnt_reg <= busy_cnt_next;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   a_busy_no_ack: assert property (BUSY |-> !s_sda_oe)
      else $error("slave drove data while busy");
   a_busy_after_stop: assert property ($rose(BUSY) |-> scl && sda && $past(sda, 4))
      else $error("write cycle began outside an idle bus");
   a_busy_span_exact: assert property ($fell(BUSY) |-> busy_cnt_reg == WR_CYC)
      else $error("write cycle length wrong");
   a_stop_release: assert property (!scl_oe && $fell(m_sda_oe) |-> !s_sda_oe [*8])
      else $error("slave held data across stop");
   a_drive_scl_low: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("slave moved data while clock high");
   a_ack_holds: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
      else $error("slave drive too short");
   a_ptr_busy_stable: assert property (BUSY && $past(BUSY) |-> $stable(PTR))
      else $error("pointer moved during write cycle");
   a_ptr_single_step: assert property ($changed(PTR) |=> $stable(PTR) [*8])
      else $error("pointer moved twice in a row");
   cover property ($rose(BUSY));
   cover property (!BUSY && $rose(s_sda_oe));
   cover property ($past(PTR) == 7'h7f && PTR == 7'h00);
endmodule

/* File: serial_eeprom_read_and_poll_bench.sv */
module serial_eeprom_read_and_poll_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import ee_pkg::*;
   localparam int WR = 3000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   ee_kind_t cmd_kind = K_WRITE;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_data = 8'h00;
   logic [7:0] cmd_len = 8'h00;
   logic rd_ready = 1'b0;
   logic cmd_ready, rd_valid, done, nack, busy;
   logic [7:0] rd_data;
   logic [ADDR_W-1:0] ptr;
   int mismatches = 0;
   int checked = 0;
   ee_bus_if bus();
   ee_bus_if bus2();

   always #4 clk = ~clk;

   ee_slave #(.WR_CYC(WR)) ee_slave_inst (.CLK(clk), .RST(rst), .CE(1'b1), .BUS(bus.slave),
      .BUSY(busy), .PTR(ptr));
   ee_master #(.QTR(60)) ee_master_inst (.CLK(clk), .RST(rst), .CE(1'b1), .BUS(bus.master),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind), .CMD_ADDR(cmd_addr),
      .CMD_DATA(cmd_data), .CMD_LEN(cmd_len), .RD_VALID(rd_valid), .RD_READY(rd_ready),
      .RD_DATA(rd_data), .DONE(done), .NACK(nack));
   // second slave, bus driven by the bench with spikes and bad codes
   if (1) begin : fault_side
      ee_slave #(.WR_CYC(WR)) ee_slave_inst (.CLK(clk), .RST(rst), .CE(1'b1), .BUS(bus2.slave),
         .BUSY(), .PTR());
   end
   ee_bus_props #(.WR_CYC(WR)) ee_bus_props_inst (.CLK(clk), .RST(rst), .scl_o(bus.scl_o),
      .scl_oe(bus.scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
      .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda),
      .BUSY(busy), .PTR(ptr));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic cmd(input ee_kind_t k, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] len, output logic nk);
      int n;
      cmd_kind = k;
      cmd_addr = a;
      cmd_data = d;
      cmd_len = len;
      cmd_valid = 1'b1;
      n = 0;
      // ready is looked at between edges, the take is the next edge
      while (cmd_ready !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      tick(1);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 60000) begin
         tick(1);
         n++;
      end
      chk({7'h0, done}, 8'h01);
      nk = nack;
   endtask

   task automatic pop(output logic [7:0] got);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 60000) begin
         tick(1);
         n++;
      end
      chk({7'h0, rd_valid}, 8'h01);
      got = rd_data;
      rd_ready = 1'b1;
      tick(1);
      rd_ready = 1'b0;
      tick(1);
   endtask

   // one bit on the second bus; sp adds 3-cycle glitches on both wires
   task automatic bb_bit(input logic b, input logic sp, output logic r);
      bus2.m_sda_oe = !b;
      tick(60);
      if (sp) begin
         bus2.scl_oe = 1'b0;
         tick(3);
         bus2.scl_oe = 1'b1;
      end
      tick(20);
      bus2.scl_oe = 1'b0;
      tick(60);
      if (sp) begin
         bus2.m_sda_oe = b;
         tick(3);
         bus2.m_sda_oe = !b;
      end
      tick(60);
      r = bus2.sda;
      bus2.scl_oe = 1'b1;
      tick(20);
   endtask

   task automatic bb_frame(input logic [7:0] v, input logic sp, output logic ack);
      logic r;
      bus2.m_sda_oe = 1'b1;
      tick(60);
      bus2.scl_oe = 1'b1;
      tick(20);
      for (int i = 7; i >= 0; i--) bb_bit(v[i], sp, r);
      bb_bit(1'b1, 1'b0, ack);
      bus2.m_sda_oe = 1'b1;
      tick(60);
      bus2.scl_oe = 1'b0;
      tick(60);
      bus2.m_sda_oe = 1'b0;
      tick(100);
   endtask

   task automatic fault_test();
      logic a;
      bb_frame(8'ha0, 1'b1, a);
      chk({7'h0, a}, 8'h00);
      bb_frame(8'hae, 1'b0, a);
      chk({7'h0, a}, 8'h00);
      bb_frame(8'hb0, 1'b0, a);
      chk({7'h0, a}, 8'h01);
   endtask

   initial begin
      tick(95000);
      mismatches++;
      conclude();
   end

   initial begin
      logic nk;
      logic [7:0] b;
      int k;
      int n;
      bus2.scl_o = 1'b0;
      bus2.m_sda_o = 1'b0;
      bus2.scl_oe = 1'b0;
      bus2.m_sda_oe = 1'b0;
      tick(20);
      rst = 1'b0;
      tick(24);
      fork
         fault_test();
      join_none
      cmd(K_WRITE, 8'h00, 8'ha5, 8'h01, nk);
      chk({7'h0, nk}, 8'h00);
      tick(30);
      chk({7'h0, busy}, 8'h01);
      chk({1'b0, ptr}, 8'h01);
      cmd(K_POLL, 8'h00, 8'h00, 8'h01, nk);
      chk({7'h0, nk}, 8'h01);
      cmd(K_POLL, 8'h00, 8'h00, 8'h01, nk);
      chk({7'h0, nk}, 8'h00);
      cmd(K_WRITE, 8'h7f, 8'h5a, 8'h01, nk);
      cmd(K_CUR, 8'h00, 8'h00, 8'h01, nk);
      chk({7'h0, nk}, 8'h01);
      cmd(K_POLL, 8'h00, 8'h00, 8'h01, nk);
      chk({7'h0, nk}, 8'h00);
      cmd(K_RAND, 8'hff, 8'h00, 8'h01, nk);
      chk({7'h0, nk}, 8'h00);
      pop(b);
      chk(b, 8'h5a);
      chk({7'h0, busy}, 8'h00);
      chk({1'b0, ptr}, 8'h00);
      cmd(K_CUR, 8'h00, 8'h00, 8'h01, nk);
      pop(b);
      chk(b, 8'ha5);
      chk({1'b0, ptr}, 8'h01);
      fork
         cmd(K_RAND, 8'h7f, 8'h00, 8'd17, nk);
         begin
            k = 0;
            n = 0;
            while (k < 1000 && n < 60000) begin
               tick(1);
               n++;
               k = (bus.scl === 1'b0) ? k + 1 : 0;
            end
            chk({7'h0, (k >= 1000)}, 8'h01);
            for (int i = 0; i < 17; i++) begin
               pop(b);
               if (i == 0) chk(b, 8'h5a);
               if (i == 1) chk(b, 8'ha5);
            end
         end
      join
      chk({7'h0, rd_valid}, 8'h00);
      chk({1'b0, ptr}, 8'h10);
      conclude();
   end
endmodule
